// ---- strap_pkg.sv ----
// Constants shared by the strap loader: register map, field positions,
// reset values and settle counts.
// Assumes a single 100 MHz clock domain and word addressed Avalon-MM access.
package strap_pkg;

    // ------------------------------------------------------------------
    // Clock and settle timing
    // ------------------------------------------------------------------
    localparam int        CLOCK_MHZ      = 100;
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;  // Covers the 2-flop pin sync

    // ------------------------------------------------------------------
    // Register map (word addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 2;
    localparam logic [1:0]  STATUS_ADDR   = 2'h0;
    localparam logic [1:0]  OVERRIDE_ADDR = 2'h1;

    // Status word field positions
    localparam int ST_CODE_LSB    = 0;   // 2 bits, effective fixed-port code
    localparam int ST_NONREM_LSB  = 2;   // 3 bits, ports 1..3 non-removable
    localparam int ST_LED_LOW     = 5;   // LED active low
    localparam int ST_CHARGE_LSB  = 6;   // 4 bits, charge enables
    localparam int ST_SELF_POWER  = 10;
    localparam int ST_STRAPS_EN   = 11;
    localparam int ST_VALID       = 12;
    localparam int ST_COMPOUND    = 13;
    localparam int ST_CFG_LSB     = 14;  // 2 bits, latched config select
    localparam int ST_ACTIVE      = 16;
    localparam int ST_BUS_POWERED = 17;

    // Override word field positions
    localparam int OV_CODE_LSB    = 0;   // 2 bits
    localparam int OV_CHARGE_LSB  = 2;   // 4 bits

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          PORTS          = 4;
    localparam int          FIXED_PORTS    = 3;
    localparam logic [1:0]  CODE_RST       = 2'h0;
    localparam logic [3:0]  CHARGE_RST     = 4'h0;
    localparam logic [1:0]  CFG_RST        = 2'h0;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

    // Config select encodings
    localparam logic [1:0]  CFG_DEFAULT     = 2'h0;
    localparam logic [1:0]  CFG_SMBUS       = 2'h1;
    localparam logic [1:0]  CFG_BUS_POWERED = 2'h2;
    localparam logic [1:0]  CFG_EEPROM      = 2'h3;

    // Loader sequencing
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_RUN    = 2'b01
    } loader_state_type;

endpackage

// ---- sync_bits.sv ----
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/1ps
`default_nettype none

module sync_bits #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_ff;

    // ------------------------------------------------------------------
    // First stage read only by the second
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            dout    <= '0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end

endmodule // sync_bits

`default_nettype wire

// ---- strap_sample_status_pins.sv ----
// Strap sampler and status pins of the hub: latches straps after reset,
// decodes fixed ports and LED polarity, drives the activity LED pin.
// Assumes hub state inputs are on this clock; pins are asynchronous.
//
// Summary of operation
// RULE1: Activity LED negated when hub unconfigured, or configured and suspended.
// RULE2: Activity LED asserted only when hub configured and not suspended.
// RULE3: Self-power detect low means no local supply; power from upstream.
// RULE4: Self-power detect high means a local self-power supply is present.
// RULE5: With straps enabled, sample both fixed-port straps at reset release.
// RULE6: Code 00: all ports removable, LED active high.
// RULE7: Code 01: port 1 fixed, LED active low.
// RULE8: Code 10: ports 1 and 2 fixed, LED active high.
// RULE9: Code 11: ports 1 to 3 fixed where present, LED active low.
// RULE10: Board must pull each strap pin firmly high or low.
// RULE11: Bidirectional strap high reads as 1, low as 0.
// RULE12: Charge-enable straps latch 1 when high, 0 when low.
// RULE13: After sampling, LED-sharing strap pin drives LED in sampled polarity.
// RULE14: Any fixed port makes the hub report itself as compound.
// RULE15: Straps ignored when configuration comes from EEPROM or SMBus.
// RULE16: Sampled straps and LED polarity hold until the next reset.
`timescale 1ns/1ps
`default_nettype none

module strap_sample_status_pins (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    // Avalon-MM slave
    input  wire logic [strap_pkg::ADDR_W-1:0]  address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [31:0]                   writedata,
    input  wire logic [3:0]                    byteenable,
    output var  logic [31:0]                   readdata,
    output var  logic                          waitrequest,
    // Strap and sense pins
    input  wire logic                          fixed_port_strap_lo,
    input  wire logic                          fixed_port_strap_hi,
    input  wire logic [1:0]                    cfg_sel,
    input  wire logic [strap_pkg::PORTS-1:0]   charge_enable_straps,
    input  wire logic                          self_power_detect,
    // Activity LED, shares the low fixed-port strap pin
    output var  logic                          activity_indicator_out,
    output var  logic                          activity_indicator_oe,
    // Hub core state
    input  wire logic                          hub_configured,
    input  wire logic                          hub_suspended,
    // Options to the hub core
    output var  logic [strap_pkg::FIXED_PORTS-1:0] nonremovable_ports,
    output var  logic                          compound_device,
    output var  logic [strap_pkg::PORTS-1:0]   charge_enable,
    output var  logic                          self_power_available,
    output var  logic                          bus_powered_mode,
    output var  logic                          straps_enabled,
    output var  logic                          options_valid
);

    import strap_pkg::*;

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_n_ff;

    // Release is synchronous so every flop leaves reset on one edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff   <= 1'b0;
            rst_sync_n_ff <= 1'b0;
        end else begin
            rst_meta_ff   <= 1'b1;
            rst_sync_n_ff <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int PIN_W = 5 + PORTS;

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_sync;
    wire              strap_lo_s;
    wire              strap_hi_s;
    wire [1:0]        cfg_sel_s;
    wire [PORTS-1:0]  charge_s;
    wire              self_power_s;

    // Pins are asynchronous to the clock, so all pass two flops
    assign pins_raw = {self_power_detect, charge_enable_straps, cfg_sel,
                       fixed_port_strap_hi, fixed_port_strap_lo};

    sync_bits #(
        .WIDTH (PIN_W)
    ) u_pin_sync (
        .clock (clock),
        .rst_n (rst_sync_n_ff),
        .din   (pins_raw),
        .dout  (pins_sync)
    );

    assign strap_lo_s   = pins_sync[0];
    assign strap_hi_s   = pins_sync[1];
    assign cfg_sel_s    = pins_sync[3:2];
    assign charge_s     = pins_sync[4 +: PORTS];
    assign self_power_s = pins_sync[PIN_W-1];

    // ------------------------------------------------------------------
    // Loader sequencing
    // ------------------------------------------------------------------
    loader_state_type state_ff;
    loader_state_type nxt_state;
    logic [1:0]       settle_cnt_ff;
    logic [1:0]       nxt_settle_cnt;
    wire              settle_done;
    wire              sample_now;

    // Wait out the synchroniser so the pin level is real, not reset zero
    assign settle_done    = (settle_cnt_ff == SETTLE_CYCLES);
    assign sample_now     = (state_ff == ST_SETTLE) && settle_done; // [RULE5]
    assign nxt_settle_cnt = settle_done ? settle_cnt_ff
                                        : 2'(settle_cnt_ff + 2'h1);

    // Sampling happens once; only a new reset returns to settle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_SETTLE: begin
                if (settle_done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                nxt_state = ST_RUN;    // [RULE16]
            end
            default: begin
                nxt_state = ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            state_ff      <= ST_SETTLE;
            settle_cnt_ff <= 2'h0;
        end else begin
            state_ff      <= nxt_state;
            settle_cnt_ff <= nxt_settle_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    logic [1:0]       cfg_ff;
    logic [1:0]       code_ff;
    logic [PORTS-1:0] charge_strap_ff;
    logic             valid_ff;

    // Captured once at release; pin high is 1, low is 0
    always_ff @(posedge clock or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            cfg_ff          <= CFG_RST;
            code_ff         <= CODE_RST;
            charge_strap_ff <= CHARGE_RST;
            valid_ff        <= 1'b0;
        end else if (sample_now) begin
            cfg_ff          <= cfg_sel_s;
            code_ff         <= {strap_hi_s, strap_lo_s};   // [RULE5] [RULE11]
            charge_strap_ff <= charge_s;                   // [RULE12]
            valid_ff        <= 1'b1;                       // [RULE16]
        end
    end

    // ------------------------------------------------------------------
    // Software override for serial configuration modes
    // ------------------------------------------------------------------
    logic [1:0]       ovr_code_ff;
    logic [PORTS-1:0] ovr_charge_ff;
    logic             wait_ff;
    logic [31:0]      rdata_ff;
    wire              req;
    wire              accept;
    wire              wr_override;

    assign req         = read | write;
    assign accept      = req && !wait_ff;
    assign wr_override = accept && write && (address == OVERRIDE_ADDR)
                         && byteenable[0];

    always_ff @(posedge clock or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            ovr_code_ff   <= CODE_RST;
            ovr_charge_ff <= CHARGE_RST;
        end else if (wr_override) begin
            ovr_code_ff   <= writedata[OV_CODE_LSB +: 2];
            ovr_charge_ff <= writedata[OV_CHARGE_LSB +: PORTS];
        end
    end

    // ------------------------------------------------------------------
    // Option decode
    // ------------------------------------------------------------------
    wire              straps_on;
    wire [1:0]        code_eff;
    wire [PORTS-1:0]  charge_eff;
    wire [FIXED_PORTS-1:0] nonrem_dec;
    wire              led_active_low;
    wire              active_state;

    // Serial config selects have bit 0 set and disable straps
    assign straps_on  = valid_ff && !cfg_ff[0];
    assign code_eff   = straps_on ? code_ff : ovr_code_ff;          // [RULE15]
    assign charge_eff = straps_on ? charge_strap_ff : ovr_charge_ff; // [RULE15]

    // Port n fixed when the code reaches n: 00 none, 01, 10, 11 up to 3
    genvar gi;
    generate
        for (gi = 0; gi < FIXED_PORTS; gi = gi + 1) begin : g_nonrem
            assign nonrem_dec[gi] = (code_eff > 2'(gi)); // [RULE6] [RULE7] [RULE8] [RULE9]
        end
    endgenerate

    // Odd codes give an active low LED, even codes active high
    assign led_active_low = code_eff[0];   // [RULE6] [RULE7] [RULE8] [RULE9] [RULE13]
    assign active_state   = hub_configured && !hub_suspended; // [RULE1] [RULE2]

    // ------------------------------------------------------------------
    // Registered outputs to the hub core and LED pin
    // ------------------------------------------------------------------
    // Pin stays an input until sampled so the strap is not overdriven
    always_ff @(posedge clock or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            nonremovable_ports     <= '0;
            compound_device        <= 1'b0;
            charge_enable          <= '0;
            self_power_available   <= 1'b0;
            bus_powered_mode       <= 1'b0;
            straps_enabled         <= 1'b0;
            options_valid          <= 1'b0;
            activity_indicator_out <= 1'b0;
            activity_indicator_oe  <= 1'b0;
        end else begin
            nonremovable_ports     <= valid_ff ? nonrem_dec : '0;
            compound_device        <= valid_ff && (code_eff != 2'h0); // [RULE14]
            charge_enable          <= valid_ff ? charge_eff : '0;
            self_power_available   <= self_power_s;   // [RULE3] [RULE4]
            bus_powered_mode       <= valid_ff && (cfg_ff == CFG_BUS_POWERED);
            straps_enabled         <= straps_on;
            options_valid          <= valid_ff;
            activity_indicator_out <= active_state ^ led_active_low; // [RULE13]
            activity_indicator_oe  <= valid_ff;                      // [RULE13]
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM read path
    // ------------------------------------------------------------------
    logic [31:0] status_word;
    logic [31:0] override_word;
    logic [31:0] read_mux;

    // Status shows latched options and live pin and hub state
    always_comb begin
        status_word = WORD_ZERO;
        status_word[ST_CODE_LSB +: 2]           = code_eff;
        status_word[ST_NONREM_LSB +: FIXED_PORTS] = nonrem_dec;
        status_word[ST_LED_LOW]                 = led_active_low;
        status_word[ST_CHARGE_LSB +: PORTS]     = charge_eff;
        status_word[ST_SELF_POWER]              = self_power_s;
        status_word[ST_STRAPS_EN]               = straps_on;
        status_word[ST_VALID]                   = valid_ff;
        status_word[ST_COMPOUND]                = (code_eff != 2'h0);
        status_word[ST_CFG_LSB +: 2]            = cfg_ff;
        status_word[ST_ACTIVE]                  = active_state;
        status_word[ST_BUS_POWERED]             = (cfg_ff == CFG_BUS_POWERED);
    end

    always_comb begin
        override_word = WORD_ZERO;
        override_word[OV_CODE_LSB +: 2]       = ovr_code_ff;
        override_word[OV_CHARGE_LSB +: PORTS] = ovr_charge_ff;
    end

    // Unmapped words read as zero
    assign read_mux = (address == STATUS_ADDR)   ? status_word   :
                      (address == OVERRIDE_ADDR) ? override_word :
                                                   WORD_ZERO;

    // ------------------------------------------------------------------
    // Avalon-MM handshake: one wait cycle, then a one-cycle answer
    // ------------------------------------------------------------------
    // Wait drops for a single cycle; data is captured the cycle before
    always_ff @(posedge clock or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            wait_ff  <= 1'b1;
            rdata_ff <= WORD_ZERO;
        end else begin
            wait_ff  <= !(req && wait_ff);
            if (req && wait_ff && read) begin
                rdata_ff <= read_mux;
            end
        end
    end

    assign waitrequest = wait_ff;
    assign readdata    = rdata_ff;

endmodule // strap_sample_status_pins

`default_nettype wire

// ---- strap_board_model.sv ----
// Board side of the hub: strap resistors, shared LED pin, power sense.
// Assumes the bench sets the strap levels before each reset release.
`timescale 1ns/1ps
`default_nettype none

module strap_board_model (
    // Board settings from the bench
    input  wire logic [1:0] b_code,
    input  wire logic [1:0] b_cfg,
    input  wire logic [3:0] b_chg,
    input  wire logic       b_pwr,
    // Shared LED drive from the hub
    input  wire logic       activity_indicator_out,
    input  wire logic       activity_indicator_oe,
    // Pin levels seen by the hub
    output wire logic       fixed_port_strap_lo,
    output wire logic       fixed_port_strap_hi,
    output wire logic [1:0] cfg_sel,
    output wire logic [3:0] charge_enable_straps,
    output wire logic       self_power_detect
);
    // Resistors give firm levels; hub drive wins on the shared pin
    assign fixed_port_strap_lo  = activity_indicator_oe ?
                                  activity_indicator_out : b_code[0];
    assign fixed_port_strap_hi  = b_code[1];
    assign cfg_sel              = b_cfg;
    assign charge_enable_straps = b_chg;
    assign self_power_detect    = b_pwr;
endmodule // strap_board_model

`default_nettype wire

// ---- strap_sample_status_pins_asserts.sv ----
// Checker on the strap loader outputs, bound to the top module.
// Assumes one clock domain and the active low reset rst_n.
`timescale 1ns/1ps
`default_nettype none

module strap_checker (
    // Clock and reset
    input wire logic                              clock,
    input wire logic                              rst_n,
    // Pins and hub state
    input wire logic                              self_power_detect,
    input wire logic                              hub_configured,
    input wire logic                              hub_suspended,
    input wire logic                              activity_indicator_out,
    input wire logic                              activity_indicator_oe,
    // Options
    input wire logic [strap_pkg::FIXED_PORTS-1:0] nonremovable_ports,
    input wire logic                              compound_device,
    input wire logic [strap_pkg::PORTS-1:0]       charge_enable,
    input wire logic                              self_power_available,
    input wire logic                              bus_powered_mode,
    input wire logic                              straps_enabled,
    input wire logic                              options_valid
);
    // Polarity bit recovered from the fixed-port thermometer
    wire led_low = ^nonremovable_ports;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_LED_IDLE: assert property (
        options_valid && $past(options_valid) && $stable(nonremovable_ports)
        && !($past(hub_configured) && !$past(hub_suspended))
        |-> activity_indicator_out == led_low)
        else $error("LED lit while hub idle");
    AST_LED_ON: assert property (
        options_valid && $past(options_valid) && $stable(nonremovable_ports)
        && $past(hub_configured) && !$past(hub_suspended)
        |-> activity_indicator_out == !led_low)
        else $error("LED dark while hub active");
    AST_SELF_POWER: assert property (
        options_valid && $past(options_valid)
        |-> self_power_available == $past(self_power_detect, 3))
        else $error("self power does not follow detect pin");
    AST_FIXED_CODE: assert property (
        nonremovable_ports inside {3'h0, 3'h1, 3'h3, 3'h7})
        else $error("fixed ports not a legal code");
    AST_COMPOUND: assert property (
        compound_device == (nonremovable_ports != 3'h0))
        else $error("compound flag disagrees with fixed ports");
    AST_HOLD: assert property (
        straps_enabled && $past(straps_enabled)
        |-> $stable(nonremovable_ports) && $stable(charge_enable))
        else $error("sampled options moved in strap mode");
    AST_VALID_STAYS: assert property (
        options_valid |=> options_valid)
        else $error("options valid dropped without reset");
    AST_LED_DRIVE: assert property (
        activity_indicator_oe == options_valid)
        else $error("LED pin drive not tied to sampling");
    AST_SAMPLE_TIME: assert property (
        $rose(rst_n) |-> !options_valid ##[3:10] options_valid)
        else $error("straps not sampled after reset release");

    // Main scenarios reached
    cover property (options_valid && nonremovable_ports == 3'h7);
    cover property (bus_powered_mode && straps_enabled);
    cover property (options_valid && !straps_enabled && compound_device);
endmodule // strap_checker

bind strap_sample_status_pins strap_checker u_chk (
    .clock, .rst_n, .self_power_detect, .hub_configured, .hub_suspended,
    .activity_indicator_out, .activity_indicator_oe, .nonremovable_ports,
    .compound_device, .charge_enable, .self_power_available,
    .bus_powered_mode, .straps_enabled, .options_valid);

`default_nettype wire

// ---- tb_strap_sample_status_pins.sv ----
// Bench for the strap loader: resets under each strap and config setting.
// Assumes the board model drives pins and Avalon tasks reach registers.
`timescale 1ns/1ps
`default_nettype none

module tb_strap_sample_status_pins;
    import strap_pkg::*;
    localparam logic [2:0] NR_TAB [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = '0;
    logic [3:0] byteenable = '0;
    logic [31:0] readdata, rd;
    logic waitrequest, activity_indicator_out, activity_indicator_oe;
    logic hub_configured = 1'b0;
    logic hub_suspended = 1'b0;
    logic [1:0] b_code = '0, b_cfg = '0, cd, cs;
    logic [3:0] b_chg = '0, chg, charge_enable, charge_enable_straps;
    logic b_pwr = 1'b0;
    logic fixed_port_strap_lo, fixed_port_strap_hi, self_power_detect;
    logic [1:0] cfg_sel;
    logic [FIXED_PORTS-1:0] nonremovable_ports;
    logic compound_device, self_power_available, bus_powered_mode;
    logic straps_enabled, options_valid;
    int error_cnt = 0;
    int total_checks = 0;

    strap_sample_status_pins dut (.clock, .rst_n, .address, .read, .write,
        .writedata, .byteenable, .readdata, .waitrequest,
        .fixed_port_strap_lo, .fixed_port_strap_hi, .cfg_sel,
        .charge_enable_straps, .self_power_detect, .activity_indicator_out,
        .activity_indicator_oe, .hub_configured, .hub_suspended,
        .nonremovable_ports, .compound_device, .charge_enable,
        .self_power_available, .bus_powered_mode, .straps_enabled,
        .options_valid);
    strap_board_model u_board (.b_code, .b_cfg, .b_chg, .b_pwr,
        .activity_indicator_out, .activity_indicator_oe,
        .fixed_port_strap_lo, .fixed_port_strap_hi, .cfg_sel,
        .charge_enable_straps, .self_power_detect);

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Waits for the accept edge; the watchdog ends a dead slave
    task automatic av_wait();
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
    endtask

    task automatic av_read(input logic [1:0] a, output logic [31:0] d);
        @(posedge clock);
        read <= 1'b1;
        address <= a;
        av_wait();
        d = readdata;
        read <= 1'b0;
    endtask

    task automatic av_write(input logic [1:0] a, input logic [31:0] d,
                            input logic [3:0] be);
        @(posedge clock);
        write <= 1'b1;
        address <= a;
        writedata <= d;
        byteenable <= be;
        av_wait();
        write <= 1'b0;
    endtask

    // Straps held steady well past the sampling edge
    task automatic do_reset(input logic [1:0] c, input logic [1:0] k,
                            input logic [3:0] g, input logic p);
        int n;
        n = 0;
        @(posedge clock);
        {b_cfg, b_code, b_chg, b_pwr} <= {c, k, g, p};
        rst_n <= 1'b0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        while (options_valid !== 1'b1 && n < 30) begin
            @(posedge clock);
            n++;
        end
        if (n >= 30) begin
            error_cnt++;
            report_and_stop();
        end
        repeat (4) @(posedge clock);
    endtask

    initial begin
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        for (int c = 0; c < 4; c++) begin
            cd = 2'(c);
            chg = {cd, ~cd};
            do_reset(CFG_DEFAULT, cd, chg, 1'b0);
            check("nonrem", nonremovable_ports, NR_TAB[c]);
            check("compound", compound_device, cd != 2'h0);
            check("charge", charge_enable, chg);
            check("straps_en", straps_enabled, 1'b1);
            av_read(STATUS_ADDR, rd);
            check("st_code", rd[ST_CODE_LSB +: 2], cd);
            check("st_low", rd[ST_LED_LOW], cd[0]);
            for (int h = 0; h < 4; h++) begin
                hub_configured <= h[0];
                hub_suspended <= h[1];
                repeat (2) @(posedge clock);
                check("led", activity_indicator_out, (h == 1) ^ cd[0]);
                check("led_oe", activity_indicator_oe, 1'b1);
            end
            b_code <= ~cd;
            b_chg <= ~chg;
            av_write(OVERRIDE_ADDR, 32'h0000_002b, 4'h1);
            repeat (10) @(posedge clock);
            check("hold_nr", nonremovable_ports, NR_TAB[c]);
            check("hold_chg", charge_enable, chg);
        end
        do_reset(CFG_BUS_POWERED, 2'h2, 4'h5, 1'b1);
        check("bus_pwr", bus_powered_mode, 1'b1);
        check("nonrem_bp", nonremovable_ports, 3'h3);
        check("self_pwr", self_power_available, 1'b1);
        b_pwr <= 1'b0;
        repeat (4) @(posedge clock);
        check("self_pwr", self_power_available, 1'b0);
        av_read(STATUS_ADDR, rd);
        check("st_pwr", rd[ST_SELF_POWER], 1'b0);
        for (int s = 0; s < 2; s++) begin
            cs = (s == 1) ? CFG_EEPROM : CFG_SMBUS;
            do_reset(cs, 2'h3, 4'hf, 1'b1);
            check("ser_nr", nonremovable_ports, 3'h0);
            check("ser_chg", charge_enable, 4'h0);
            check("ser_en", straps_enabled, 1'b0);
            av_write(OVERRIDE_ADDR, 32'h0000_002b, 4'h0);
            av_write(STATUS_ADDR, 32'hffff_ffff, 4'hf);
            av_read(OVERRIDE_ADDR, rd);
            check("ov_be", rd, 32'h0);
            av_write(OVERRIDE_ADDR, 32'hffff_ff2b, 4'h1);
            hub_configured <= 1'b1;
            hub_suspended <= 1'b0;
            repeat (3) @(posedge clock);
            check("ov_nr", nonremovable_ports, 3'h7);
            check("ov_chg", charge_enable, 4'ha);
            check("ov_cmp", compound_device, 1'b1);
            check("ov_led", activity_indicator_out, 1'b0);
            av_read(OVERRIDE_ADDR, rd);
            check("ov_rd", rd, 32'h0000_002b);
            av_read(2'h2, rd);
            check("unmapped", rd, 32'h0);
            av_read(STATUS_ADDR, rd);
            check("st_cfg", rd[ST_CFG_LSB +: 2], cs);
        end
        report_and_stop();
    end
endmodule // tb_strap_sample_status_pins

`default_nettype wire
